// ### logic/flash_seq_defines.svh
// timing counts and counter width for the host-side flash sequencer
// assumes a 50 MHz clock; included by the timer and host design modules
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define VCC_SETUP_US 2
`define RP_RECOVERY_NS 500
`define OE_HOLD_BUSY_NS 80
`define LOCK_SETUP_NS 80
`define BUSY_ASSERT_NS 80
`define PROG_MAX_MS 80
`define ERASE_MAX_MS 600
`define VCC_SETUP_CYC ((`VCC_SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_RECOVERY_CYC ((`RP_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OE_HOLD_CYC ((`OE_HOLD_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_SETUP_CYC ((`LOCK_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_ASSERT_CYC ((`BUSY_ASSERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MAX_CYC (`PROG_MAX_MS * 50000)
`define ERASE_MAX_CYC (`ERASE_MAX_MS * 50000)
`define WE_LOW_CYC 4
`define WE_HIGH_CYC 2
`define CNT_W 25

`endif

// ### logic/flash_seq_pkg.sv
// types shared by the flash sequencer modules
// no dependencies
package flash_seq_pkg;
    typedef enum logic [1:0] {op_read, op_program, op_erase, op_lock} op_type;
    typedef enum logic [3:0] {
        st_off, st_vcc_wait, st_recover, st_idle, st_lock_setup, st_we_low,
        st_we_high, st_busy_wait, st_busy, st_status_hold, st_read, st_done
    } state_type;
endpackage

// ### logic/flash_seq_timer.sv
// down counter with load and done flag
// one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_seq_timer
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic load,
    input wire logic [`CNT_W-1:0] load_val,
    // status
    output logic expired
);
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = load_val;
        else if (cnt_q != '0)
            cnt_d = cnt_q - `CNT_W'(1);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    // not gated by load: the host decides load from this flag, gating it would close a loop
    assign expired = (cnt_q == '0);
endmodule
`default_nettype wire

// ### logic/flash_seq_host.sv
// host controller sequencing an asynchronous parallel nor flash through its strobes
// assumes supply-good comes from a monitor; data and address paths handled elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_seq_host
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // supply monitor
    input wire logic vcc_good,
    // user request
    input wire logic req_valid,
    input wire flash_seq_pkg::op_type req_op,
    input wire logic req_unlock,
    output logic req_ready,
    output logic done,
    output logic timeout,
    output logic refused,
    // flash pins
    input wire logic ready_busy_n,
    output logic reset_powerdown_n,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic write_protect_n
);
    flash_seq_pkg::state_type state_q, state_d;
    flash_seq_pkg::op_type op_q, op_d;
    logic rp_q, rp_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d, wp_q, wp_d;
    logic rdy_q, rdy_d, done_q, done_d, to_q, to_d, ref_q, ref_d;
    logic tmr_load;
    logic [`CNT_W-1:0] tmr_val;
    logic expired;
    logic [`CNT_W-1:0] wd_q, wd_d;

    function automatic logic [`CNT_W-1:0] cyc(input int n);
        cyc = `CNT_W'(n);
    endfunction

    flash_seq_timer u_timer
    (
        .clk(clk),
        .rst_b(rst_b),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(expired)
    );

    always_comb
    begin
        state_d = state_q;
        op_d = op_q;
        rp_d = rp_q;
        ce_d = ce_q;
        oe_d = oe_q;
        we_d = we_q;
        wp_d = wp_q;
        rdy_d = 1'b0;
        done_d = 1'b0;
        to_d = 1'b0;
        ref_d = 1'b0;
        wd_d = (wd_q != '0) ? wd_q - `CNT_W'(1) : wd_q;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_q)
            flash_seq_pkg::st_off:
            begin
                rp_d = 1'b0;
                if (vcc_good)
                begin
                    tmr_load = 1'b1;
                    tmr_val = cyc(`VCC_SETUP_CYC);
                    state_d = flash_seq_pkg::st_vcc_wait;
                end
            end
            flash_seq_pkg::st_vcc_wait:
                if (expired)
                begin
                    rp_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = cyc(`RP_RECOVERY_CYC);
                    state_d = flash_seq_pkg::st_recover;
                end
            flash_seq_pkg::st_recover:
                if (expired)
                    state_d = flash_seq_pkg::st_idle;
            flash_seq_pkg::st_idle:
            begin
                rdy_d = 1'b1;
                if (req_valid && req_ready)
                begin
                    rdy_d = 1'b0;
                    op_d = req_op;
                    ce_d = 1'b0;
                    wp_d = req_unlock;
                    if (req_op == flash_seq_pkg::op_read)
                    begin
                        oe_d = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = cyc(`WE_LOW_CYC);
                        state_d = flash_seq_pkg::st_read;
                    end
                    else
                    begin
                        // lock setup time covers every write, cheap and safe
                        tmr_load = 1'b1;
                        tmr_val = cyc(`LOCK_SETUP_CYC);
                        state_d = flash_seq_pkg::st_lock_setup;
                    end
                end
            end
            flash_seq_pkg::st_lock_setup:
                if (expired)
                begin
                    we_d = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = cyc(`WE_LOW_CYC);
                    state_d = flash_seq_pkg::st_we_low;
                end
            flash_seq_pkg::st_we_low:
                if (expired)
                begin
                    we_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = cyc(`BUSY_ASSERT_CYC);
                    state_d = flash_seq_pkg::st_busy_wait;
                end
            flash_seq_pkg::st_busy_wait:
                if (!ready_busy_n)
                begin
                    wd_d = (op_q == flash_seq_pkg::op_erase) ? cyc(`ERASE_MAX_CYC)
                                                             : cyc(`PROG_MAX_CYC);
                    tmr_load = 1'b1;
                    tmr_val = cyc(`OE_HOLD_CYC);
                    state_d = flash_seq_pkg::st_status_hold;
                end
                else if (expired)
                begin
                    // no busy seen: device refused it, e.g. locked block
                    ref_d = 1'b1;
                    ce_d = 1'b1;
                    state_d = flash_seq_pkg::st_done;
                end
            flash_seq_pkg::st_status_hold:
                if (expired)
                begin
                    oe_d = 1'b0;
                    state_d = flash_seq_pkg::st_busy;
                end
            flash_seq_pkg::st_busy:
                if (ready_busy_n)
                begin
                    oe_d = 1'b1;
                    ce_d = 1'b1;
                    done_d = 1'b1;
                    state_d = flash_seq_pkg::st_done;
                end
                else if (wd_q == '0)
                begin
                    oe_d = 1'b1;
                    ce_d = 1'b1;
                    to_d = 1'b1;
                    state_d = flash_seq_pkg::st_done;
                end
            flash_seq_pkg::st_read:
                if (expired)
                begin
                    oe_d = 1'b1;
                    ce_d = 1'b1;
                    done_d = 1'b1;
                    state_d = flash_seq_pkg::st_done;
                end
            flash_seq_pkg::st_done:
            begin
                wp_d = 1'b0;
                state_d = flash_seq_pkg::st_idle;
            end
            default:
                state_d = flash_seq_pkg::st_off;
        endcase
        // supply loss overrides the state, pins, ready and timer load (not done, timeout or refused) and parks the pins
        if (!vcc_good)
        begin
            state_d = flash_seq_pkg::st_off;
            rp_d = 1'b0;
            ce_d = 1'b1;
            oe_d = 1'b1;
            we_d = 1'b1;
            wp_d = 1'b0;
            rdy_d = 1'b0;
            tmr_load = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= flash_seq_pkg::st_off;
            op_q <= flash_seq_pkg::op_read;
            rp_q <= 1'b0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            wp_q <= 1'b0;
            rdy_q <= 1'b0;
            done_q <= 1'b0;
            to_q <= 1'b0;
            ref_q <= 1'b0;
            wd_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            rp_q <= rp_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            wp_q <= wp_d;
            rdy_q <= rdy_d;
            done_q <= done_d;
            to_q <= to_d;
            ref_q <= ref_d;
            wd_q <= wd_d;
        end
    end

    assign reset_powerdown_n = rp_q;
    assign chip_enable_n = ce_q;
    assign output_enable_n = oe_q;
    assign write_enable_n = we_q;
    assign write_protect_n = wp_q;
    assign req_ready = rdy_q;
    assign done = done_q;
    assign timeout = to_q;
    assign refused = ref_q;

    // helper: cycles since reset/powerdown rose
    logic [15:0] rp_age_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rp_age_q <= '0;
        else if (!rp_q)
            rp_age_q <= '0;
        else if (rp_age_q != 16'hFFFF)
            rp_age_q <= rp_age_q + 16'h0001;
    end

    sequence we_rise_s;
        $rose(write_enable_n);
    endsequence

    chk_low_before_vcc: assert property (@(posedge clk) disable iff (!rst_b)
        !vcc_good |=> !reset_powerdown_n) else $error("rp high without supply");
    chk_vcc_setup: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(vcc_good) |=> !reset_powerdown_n [*8] ##92 !reset_powerdown_n) else $error("rp rose early");
    chk_rp_held: assert property (@(posedge clk) disable iff (!rst_b)
        (!chip_enable_n && vcc_good) |-> reset_powerdown_n) else $error("rp low in cycle");
    chk_read_recover: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(output_enable_n) |-> rp_age_q >= 16'(`RP_RECOVERY_CYC)) else $error("read too soon");
    chk_write_recover: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(write_enable_n) |-> rp_age_q >= 16'(`RP_RECOVERY_CYC)) else $error("write too soon");
    chk_oe_hold: assert property (@(posedge clk) disable iff (!rst_b)
        we_rise_s |-> output_enable_n [*4]) else $error("oe hold short");
    chk_wp_setup: assert property (@(posedge clk) disable iff (!rst_b)
        we_rise_s |-> $stable(write_protect_n) [*1] ##0 $past(write_protect_n, 4) == write_protect_n)
        else $error("wp setup short");
    chk_busy_end: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == flash_seq_pkg::st_busy && ready_busy_n && vcc_good) |=> done)
        else $error("done missing");
endmodule
`default_nettype wire

// ### verification/flash_dev_model.sv
// behavioural flash device: lock bits, busy timing, host pin timing checks
// assumes a 20 ns bench clock; the bench passes the current op and block
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
(
    // clock and bench side
    input wire logic clk,
    input wire logic vcc_good,
    input wire flash_seq_pkg::op_type req_op,
    input wire logic [1:0] blk,
    input wire logic [15:0] busy_cyc,
    // flash pins
    input wire logic reset_powerdown_n,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic write_protect_n,
    output logic ready_busy_n,
    // host timing faults seen
    output int viol_count
);
    logic [3:0] lock_q = 4'h0;
    int left = 0;
    time vcc_t = 0;
    time rp_t = 0;
    time we_t = 0;
    time wp_t = 0;
    initial ready_busy_n = 1'b1;
    initial viol_count = 0;
    always @(posedge vcc_good) vcc_t = $time;
    // supply loss drops any operation in flight
    always @(negedge vcc_good)
    begin
        left = 0;
        ready_busy_n = 1'b1;
    end
    always @(write_protect_n) wp_t = $time;
    always @(posedge reset_powerdown_n)
    begin
        if (!vcc_good || $time - vcc_t < 2000) viol_count++;
        rp_t = $time;
    end
    always @(negedge reset_powerdown_n)
        if (vcc_good && !ready_busy_n) viol_count++;
    always @(negedge write_enable_n or negedge output_enable_n)
        if ($time - rp_t < 500 || !reset_powerdown_n) viol_count++;
    always @(negedge output_enable_n)
        if (!ready_busy_n && $time - we_t < 80) viol_count++;
    always @(posedge write_enable_n)
    begin
        we_t = $time;
        if (reset_powerdown_n && $time - wp_t < 80) viol_count++;
        if (chip_enable_n === 1'b0 && (req_op == flash_seq_pkg::op_lock || !lock_q[blk] || write_protect_n))
        begin
            if (req_op == flash_seq_pkg::op_lock) lock_q[blk] = 1'b1;
            if (req_op == flash_seq_pkg::op_erase) lock_q[blk] = 1'b0;
            // off the clock edge so the host never samples a race
            #30 ready_busy_n = 1'b0;
            left = busy_cyc;
        end
    end
    always @(posedge clk)
        if (left > 0)
        begin
            left <= left - 1;
            if (left == 1) ready_busy_n <= 1'b1;
        end
endmodule
`default_nettype wire

// ### verification/flash_write_protect_timing_bench.sv
// self-checking bench for the host flash sequencer
// assumes the device model above stands on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_write_protect_timing_bench;
    logic clk, rst_b, vcc_good, req_valid, req_unlock, req_ready, done, timeout, refused;
    logic ready_busy_n, reset_powerdown_n, chip_enable_n, output_enable_n, write_enable_n, write_protect_n;
    flash_seq_pkg::op_type req_op;
    logic [1:0] blk;
    logic [15:0] busy_cyc;
    int viol_count, err_count, check_count;

    flash_seq_host u_dut (.clk, .rst_b, .vcc_good, .req_valid, .req_op, .req_unlock, .req_ready, .done,
        .timeout, .refused, .ready_busy_n, .reset_powerdown_n, .chip_enable_n, .output_enable_n,
        .write_enable_n, .write_protect_n);
    flash_dev_model u_dev (.clk, .vcc_good, .req_op, .blk, .busy_cyc, .reset_powerdown_n, .chip_enable_n,
        .output_enable_n, .write_enable_n, .write_protect_n, .ready_busy_n, .viol_count);

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_of_test;
        if (viol_count != 0) check(1'b0, "host broke pin timing at the device");
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wait_high(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= lim)
        begin
            check(1'b0, "wait ran out");
            end_of_test;
        end
    endtask

    task automatic power_up;
        int n;
        vcc_good <= 1'b1;
        wait_high(reset_powerdown_n, 500, n);
        check(n >= 100, "powerdown released early");
        wait_high(req_ready, 500, n);
        check(n >= 25, "ready before recovery");
    endtask

    // op codes: 0 read, 1 program, 2 erase, 3 lock
    task automatic start(input logic [1:0] o, input logic [1:0] b, input logic u, input int bc);
        int n;
        wait_high(req_ready, 100, n);
        req_op <= flash_seq_pkg::op_type'(o);
        blk <= b;
        req_unlock <= u;
        busy_cyc <= 16'(bc);
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask

    task automatic do_op(input logic [1:0] o, input logic [1:0] b, input logic u, input int bc, input logic ok);
        int n;
        logic busy_seen;
        n = 0;
        busy_seen = 1'b0;
        start(o, b, u, bc);
        while (done !== 1'b1 && refused !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
            if (ready_busy_n === 1'b0) busy_seen = 1'b1;
        end
        check(done === ok && refused === !ok && timeout === 1'b0, "wrong outcome");
        check(busy_seen === (ok && o != 2'h0) && (o != 2'h0 || n <= 8), "busy or length wrong");
        if (n >= 20000) end_of_test;
    endtask

    // supply lost while a program is busy
    task automatic brownout;
        start(2'h1, 2'h0, 1'b0, 2000);
        repeat (20) @(posedge clk);
        vcc_good <= 1'b0;
        repeat (3) @(posedge clk);
        check(reset_powerdown_n === 1'b0 && write_enable_n === 1'b1 && req_ready === 1'b0, "not parked");
        check(ready_busy_n === 1'b1, "device still busy");
        power_up;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        rst_b = 1'b0;
        vcc_good = 1'b0;
        req_valid = 1'b0;
        req_op = flash_seq_pkg::op_read;
        req_unlock = 1'b0;
        blk = 2'h0;
        busy_cyc = 16'h000A;
        err_count = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk);
        check(reset_powerdown_n === 1'b0 && req_ready === 1'b0, "left powerdown without supply");
        power_up;
        do_op(2'h0, 2'h0, 1'b0, 10, 1'b1);
        do_op(2'h1, 2'h0, 1'b0, 10, 1'b1);
        do_op(2'h3, 2'h1, 1'b0, 10, 1'b1);
        do_op(2'h1, 2'h1, 1'b0, 10, 1'b0);
        do_op(2'h2, 2'h1, 1'b0, 10, 1'b0);
        do_op(2'h2, 2'h1, 1'b1, 400, 1'b1);
        do_op(2'h1, 2'h1, 1'b0, 10, 1'b1);
        brownout;
        do_op(2'h0, 2'h2, 1'b0, 10, 1'b1);
        end_of_test;
    end

    initial
    begin
        #2000000;
        check(1'b0, "run too long");
        end_of_test;
    end
endmodule
`default_nettype wire
